// >>> inc/rmeb_defs.vh
// Constants for the receive rate-match elastic buffer
// Summary of operation
// - Thirty-two entry elastic store absorbs clock difference
// - Entry holds 64 payload plus 8 flags
// - Empty buffer sends local fault words instead
// - Occupancy regulated toward half capacity
// - Above half, idle sequences dropped before writing
// - Below half, idle sequences added on read
// - Half headroom absorbs sixty-four idle sequences
// - Write into full buffer is discarded
// - From half, 640 KB passes at 200ppm
`ifndef RMEB_DEFS_VH
`define RMEB_DEFS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define RMEB_DEPTH          32
`define RMEB_AW             5
`define RMEB_DATA_W         64
`define RMEB_CTRL_W         8
`define RMEB_WORD_W         72
`define RMEB_OUT_DEPTH      16
`define RMEB_OUT_AW         4
`define RMEB_SEQ_PER_WORD   4
`define RMEB_ABSORB_SEQ     64

// ----------------------------------------
// Code words
// ----------------------------------------
`define RMEB_IDLE_DATA      64'h0707_0707_0707_0707
`define RMEB_IDLE_CTRL      8'hFF
`define RMEB_LF_DATA        64'h0100_0000_0100_009C
`define RMEB_LF_CTRL        8'h11
`define RMEB_START_CODE     8'hFB
`define RMEB_TERM_CODE      8'hFD

// ----------------------------------------
// Timing
// ----------------------------------------
`define RMEB_CLK_PERIOD_NS  40
`define RMEB_LINK_PERIOD_NS 320
`define RMEB_RD_DIV         (`RMEB_LINK_PERIOD_NS / `RMEB_CLK_PERIOD_NS)

`endif

// >>> core/rmeb_fifo.v
// Output FIFO with registered head word, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rmeb_fifo #(
  parameter W     = 72,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset_n,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output reg          out_valid_ff,
  input  wire         out_ready,
  output reg  [W-1:0] out_data_ff
);

  reg  [W-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr_ff;
  reg  [AW-1:0] rd_ptr_ff;
  reg  [AW:0]   count_ff;
  wire          push;
  wire          pop;

  localparam integer DEPTH_I  = DEPTH;
  localparam [AW:0]  FULL_CNT = DEPTH_I[AW:0];

  assign in_ready = (count_ff != FULL_CNT);
  assign push     = in_valid & in_ready;
  // Head register refills whenever empty or being taken
  assign pop      = (count_ff != {(AW+1){1'b0}}) & (~out_valid_ff | out_ready);

  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_ff] <= in_data;
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_ff    <= {AW{1'b0}};
      rd_ptr_ff    <= {AW{1'b0}};
      count_ff     <= {(AW+1){1'b0}};
      out_valid_ff <= 1'b0;
      out_data_ff  <= {W{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
      begin
        rd_ptr_ff    <= rd_ptr_ff + 1'b1;
        out_data_ff  <= mem[rd_ptr_ff];
        out_valid_ff <= 1'b1;
      end
      else if (out_ready)
        out_valid_ff <= 1'b0;
      case ({push, pop})
        2'b10:   count_ff <= count_ff + 1'b1;
        2'b01:   count_ff <= count_ff - 1'b1;
        default: count_ff <= count_ff;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> core/rmeb_top.v
// Receive rate-match elastic buffer between the PCS decoder and MAC receive logic
`timescale 1ns/1ps
`default_nettype none
`include "rmeb_defs.vh"

module rmeb_top #(
  parameter DEPTH     = `RMEB_DEPTH,
  parameter AW        = `RMEB_AW,
  parameter OUT_DEPTH = `RMEB_OUT_DEPTH,
  parameter OUT_AW    = `RMEB_OUT_AW,
  parameter RD_DIV    = `RMEB_RD_DIV
) (
  // Clock and reset
  input  wire                      core_clk,
  input  wire                      reset_n,
  // Decoded words from the PCS receive path
  input  wire                      rx_link_clk,
  input  wire                      rx_link_valid,
  input  wire [`RMEB_DATA_W-1:0]   rx_link_data,
  input  wire [`RMEB_CTRL_W-1:0]   rx_link_ctrl,
  // Words to the MAC receive logic
  output wire                      mac_valid,
  input  wire                      mac_ready,
  output wire [`RMEB_DATA_W-1:0]   mac_data,
  output wire [`RMEB_CTRL_W-1:0]   mac_ctrl,
  // Status
  output reg  [AW:0]               fill_level_ff,
  output reg                       drop_pulse_ff,
  output reg                       delete_pulse_ff,
  output reg                       insert_pulse_ff,
  output reg                       fault_pulse_ff
);

  localparam integer HALF_I   = DEPTH / 2;
  localparam integer DEPTH_I  = DEPTH;
  localparam integer DIV_I    = RD_DIV - 1;
  localparam [AW:0] HALF      = HALF_I[AW:0];
  localparam [AW:0] FULL_CNT  = DEPTH_I[AW:0];
  localparam [AW:0] ZERO_CNT  = {(AW+1){1'b0}};
  localparam [7:0]  DIV_LAST  = DIV_I[7:0];
  localparam [`RMEB_WORD_W-1:0] IDLE_WORD = {`RMEB_IDLE_CTRL, `RMEB_IDLE_DATA};
  localparam [`RMEB_WORD_W-1:0] LF_WORD   = {`RMEB_LF_CTRL, `RMEB_LF_DATA};

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [AW:0] gray2bin;
    input [AW:0] g;
    integer i;
    begin
      gray2bin[AW] = g[AW];
      for (i = AW - 1; i >= 0; i = i - 1)
        gray2bin[i] = gray2bin[i+1] ^ g[i];
    end
  endfunction

  function [AW:0] bin2gray;
    input [AW:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  // True when any control lane carries the given code
  function lane_has;
    input [`RMEB_WORD_W-1:0] w;
    input [7:0]              code;
    integer i;
    begin
      lane_has = 1'b0;
      for (i = 0; i < `RMEB_CTRL_W; i = i + 1)
        if (w[`RMEB_DATA_W+i] && (w[8*i +: 8] == code))
          lane_has = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // Link input synchronisers
  // ----------------------------------------
  // Link clock is sampled, not used as a clock: the whole block stays in one domain
  reg                       lclk_s1_ff;
  reg                       lclk_s2_ff;
  reg                       lclk_s3_ff;
  reg  [`RMEB_WORD_W:0]     din_s1_ff;
  reg  [`RMEB_WORD_W:0]     din_s2_ff;
  wire                      link_edge;
  wire [`RMEB_WORD_W-1:0]   in_word;
  wire                      in_valid;

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      lclk_s1_ff <= 1'b0;
      lclk_s2_ff <= 1'b0;
      lclk_s3_ff <= 1'b0;
      din_s1_ff  <= {(`RMEB_WORD_W+1){1'b0}};
      din_s2_ff  <= {(`RMEB_WORD_W+1){1'b0}};
    end
    else
    begin
      lclk_s1_ff <= rx_link_clk;
      lclk_s2_ff <= lclk_s1_ff;
      lclk_s3_ff <= lclk_s2_ff;
      din_s1_ff  <= {rx_link_valid, rx_link_ctrl, rx_link_data};
      din_s2_ff  <= din_s1_ff;
    end
  end

  // Data launched on the falling link edge has settled for half a period here
  assign link_edge = lclk_s2_ff & ~lclk_s3_ff;
  assign in_word   = din_s2_ff[`RMEB_WORD_W-1:0];
  assign in_valid  = din_s2_ff[`RMEB_WORD_W];

  // ----------------------------------------
  // Elastic store
  // ----------------------------------------
  reg  [`RMEB_WORD_W-1:0] store [0:DEPTH-1];

  // ----------------------------------------
  // Write side
  // ----------------------------------------
  reg  [AW:0]  wr_bin_ff;
  reg  [AW:0]  wr_gray_ff;
  reg  [AW:0]  rd_gray_ff;
  reg  [AW:0]  rd_gray_w1_ff;
  reg  [AW:0]  rd_gray_w2_ff;
  reg          wr_frame_ff;
  wire [AW:0]  wr_fill;
  wire         wr_full;
  wire         in_idle;
  wire         do_delete;
  wire         do_drop;
  wire         do_write;
  wire [AW:0]  nxt_wr_bin;

  assign wr_fill   = wr_bin_ff - gray2bin(rd_gray_w2_ff);
  assign wr_full   = (wr_fill == FULL_CNT);
  assign in_idle   = (in_word == IDLE_WORD);
  // Half the store is headroom: 16 words of 4 idle sequences each
  assign do_delete = link_edge & in_valid & in_idle & ~wr_frame_ff
                     & (wr_fill > HALF);
  assign do_drop   = link_edge & in_valid & ~do_delete & wr_full;
  assign do_write  = link_edge & in_valid & ~do_delete & ~wr_full;
  assign nxt_wr_bin = wr_bin_ff + 1'b1;

  always @(posedge core_clk)
  begin
    if (do_write)
      store[wr_bin_ff[AW-1:0]] <= in_word;
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      wr_bin_ff       <= {(AW+1){1'b0}};
      wr_gray_ff      <= {(AW+1){1'b0}};
      rd_gray_w1_ff   <= {(AW+1){1'b0}};
      rd_gray_w2_ff   <= {(AW+1){1'b0}};
      wr_frame_ff     <= 1'b0;
      drop_pulse_ff   <= 1'b0;
      delete_pulse_ff <= 1'b0;
    end
    else
    begin
      rd_gray_w1_ff   <= rd_gray_ff;
      rd_gray_w2_ff   <= rd_gray_w1_ff;
      drop_pulse_ff   <= do_drop;
      delete_pulse_ff <= do_delete;
      if (do_write)
      begin
        wr_bin_ff  <= nxt_wr_bin;
        wr_gray_ff <= bin2gray(nxt_wr_bin);
      end
      if (link_edge & in_valid)
      begin
        if (lane_has(in_word, `RMEB_START_CODE))
          wr_frame_ff <= 1'b1;
        else if (lane_has(in_word, `RMEB_TERM_CODE))
          wr_frame_ff <= 1'b0;
      end
      else if (link_edge)
        wr_frame_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read side
  // ----------------------------------------
  reg  [AW:0]              rd_bin_ff;
  reg  [AW:0]              wr_gray_r1_ff;
  reg  [AW:0]              wr_gray_r2_ff;
  reg  [7:0]               div_ff;
  reg                      last_idle_ff;
  reg                      rd_frame_ff;
  reg                      push_valid;
  reg  [`RMEB_WORD_W-1:0]  push_word;
  reg                      push_pop;
  reg                      push_fault;
  reg                      push_insert;
  wire [AW:0]              rd_fill;
  wire                     rd_empty;
  wire                     tick;
  wire                     fifo_ready;
  wire [AW:0]              nxt_rd_bin;

  assign rd_fill    = gray2bin(wr_gray_r2_ff) - rd_bin_ff;
  assign rd_empty   = (rd_fill == ZERO_CNT);
  // Nominal local word rate matches the link word rate
  assign tick       = (div_ff == DIV_LAST);
  assign nxt_rd_bin = rd_bin_ff + 1'b1;

  // A stalled MAC holds off the tick, so back-pressure reaches the store
  always @*
  begin
    push_valid  = 1'b0;
    push_word   = LF_WORD;
    push_pop    = 1'b0;
    push_fault  = 1'b0;
    push_insert = 1'b0;
    if (tick & fifo_ready)
    begin
      push_valid = 1'b1;
      if (rd_empty)
      begin
        push_word  = LF_WORD;
        push_fault = 1'b1;
      end
      else if ((rd_fill < HALF) & last_idle_ff & ~rd_frame_ff)
      begin
        push_word   = IDLE_WORD;
        push_insert = 1'b1;
      end
      else
      begin
        push_word = store[rd_bin_ff[AW-1:0]];
        push_pop  = 1'b1;
      end
    end
  end

  always @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      rd_bin_ff       <= {(AW+1){1'b0}};
      rd_gray_ff      <= {(AW+1){1'b0}};
      wr_gray_r1_ff   <= {(AW+1){1'b0}};
      wr_gray_r2_ff   <= {(AW+1){1'b0}};
      div_ff          <= 8'h00;
      last_idle_ff    <= 1'b0;
      rd_frame_ff     <= 1'b0;
      fill_level_ff   <= {(AW+1){1'b0}};
      insert_pulse_ff <= 1'b0;
      fault_pulse_ff  <= 1'b0;
    end
    else
    begin
      wr_gray_r1_ff   <= wr_gray_ff;
      wr_gray_r2_ff   <= wr_gray_r1_ff;
      fill_level_ff   <= rd_fill;
      insert_pulse_ff <= push_insert;
      fault_pulse_ff  <= push_fault;
      if (!tick)
        div_ff <= div_ff + 8'h01;
      else if (fifo_ready)
        div_ff <= 8'h00;
      if (push_pop)
      begin
        rd_bin_ff  <= nxt_rd_bin;
        rd_gray_ff <= bin2gray(nxt_rd_bin);
      end
      if (push_valid)
      begin
        last_idle_ff <= (push_word == IDLE_WORD);
        if (lane_has(push_word, `RMEB_START_CODE))
          rd_frame_ff <= 1'b1;
        else if (lane_has(push_word, `RMEB_TERM_CODE) | push_fault)
          rd_frame_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Output FIFO
  // ----------------------------------------
  wire [`RMEB_WORD_W-1:0] out_word;

  rmeb_fifo #(
    .W     (`RMEB_WORD_W),
    .DEPTH (OUT_DEPTH),
    .AW    (OUT_AW)
  ) u_out_fifo (
    .clk          (core_clk),
    .reset_n      (reset_n),
    .in_valid     (push_valid),
    .in_ready     (fifo_ready),
    .in_data      (push_word),
    .out_valid_ff (mac_valid),
    .out_ready    (mac_ready),
    .out_data_ff  (out_word)
  );

  assign mac_data = out_word[`RMEB_DATA_W-1:0];
  assign mac_ctrl = out_word[`RMEB_WORD_W-1:`RMEB_DATA_W];

endmodule

`default_nettype wire

// >>> sim/rmeb_assertions.sv
// Concurrent checks on the ports of the rate-match elastic buffer
`timescale 1ns/1ps
`default_nettype none
`include "rmeb_defs.vh"

module rmeb_chk #(
  parameter AW = 5
) (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    reset_n,
  // Read side
  input wire logic                    mac_valid,
  input wire logic                    mac_ready,
  input wire logic [`RMEB_DATA_W-1:0] mac_data,
  input wire logic [`RMEB_CTRL_W-1:0] mac_ctrl,
  // Status
  input wire logic [AW:0]             fill_level_ff,
  input wire logic                    drop_pulse_ff,
  input wire logic                    delete_pulse_ff,
  input wire logic                    insert_pulse_ff,
  input wire logic                    fault_pulse_ff
);
  localparam HALF = `RMEB_DEPTH / 2;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Words arrive at least six cycles apart, so deletions cannot bunch
  sequence s_no_del;
    !delete_pulse_ff [*5];
  endsequence
  property p_fill_max;
    fill_level_ff <= `RMEB_DEPTH;
  endproperty
  property p_drop_full;
    drop_pulse_ff |-> fill_level_ff >= `RMEB_DEPTH - 2;
  endproperty
  property p_del_half;
    delete_pulse_ff |-> fill_level_ff >= HALF - 1;
  endproperty
  property p_del_gap;
    delete_pulse_ff |=> s_no_del;
  endproperty
  property p_ins_half;
    insert_pulse_ff |-> fill_level_ff <= HALF;
  endproperty
  property p_fault_empty;
    fault_pulse_ff |-> fill_level_ff <= 1 && !insert_pulse_ff;
  endproperty
  property p_lf_word;
    mac_valid && mac_ctrl == `RMEB_LF_CTRL |-> mac_data == `RMEB_LF_DATA;
  endproperty
  property p_hold;
    mac_valid && !mac_ready |=> mac_valid && $stable(mac_data) && $stable(mac_ctrl);
  endproperty
  a_fill_max: assert property (p_fill_max) else $error("fill above depth");
  a_drop_full: assert property (p_drop_full) else $error("drop while not full");
  a_del_half: assert property (p_del_half) else $error("delete below half");
  a_del_gap: assert property (p_del_gap) else $error("deletes too close");
  a_ins_half: assert property (p_ins_half) else $error("insert above half");
  a_fault_empty: assert property (p_fault_empty) else $error("fault while stored");
  a_lf_word: assert property (p_lf_word) else $error("bad fault word");
  a_hold: assert property (p_hold) else $error("word changed unaccepted");
endmodule
`default_nettype wire

// >>> sim/rmeb_link_src.sv
// Model of the receive decoder handing words over on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "rmeb_defs.vh"

module rmeb_link_src (
  // Control from the bench
  input  wire logic                    en,
  // Link side
  output logic                         link_clk,
  output logic                         link_valid,
  output logic [`RMEB_DATA_W-1:0]      link_data,
  output logic [`RMEB_CTRL_W-1:0]      link_ctrl
);
  logic [`RMEB_WORD_W-1:0] q[$];
  logic [`RMEB_WORD_W-1:0] w;
  task send(input logic [`RMEB_WORD_W-1:0] x);
    q.push_back(x);
  endtask
  // Recovered clock runs free, offset so it never lines up with the core clock
  initial
  begin
    link_clk = 1'b0;
    link_valid = 1'b0;
    {link_ctrl, link_data} = '0;
    #7;
    forever #(`RMEB_LINK_PERIOD_NS / 2) link_clk = ~link_clk;
  end
  // Change on the falling edge so the word is settled around the rising edge
  always @(negedge link_clk)
  begin
    if (!en)
    begin
      link_valid <= 1'b0;
      {link_ctrl, link_data} <= ~{link_ctrl, link_data};
    end
    else
    begin
      w = (q.size() > 0) ? q.pop_front() : {`RMEB_IDLE_CTRL, `RMEB_IDLE_DATA};
      link_valid <= 1'b1;
      {link_ctrl, link_data} <= w;
    end
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the rate-match elastic buffer
`timescale 1ns/1ps
`default_nettype none
`include "rmeb_defs.vh"

module testbench;
  localparam logic [71:0] IDLE = {`RMEB_IDLE_CTRL, `RMEB_IDLE_DATA};
  localparam logic [71:0] LF   = {`RMEB_LF_CTRL, `RMEB_LF_DATA};
  logic        core_clk;
  logic        reset_n;
  logic        mac_ready;
  logic        en;
  logic        lclk;
  logic        lvalid;
  logic [63:0] ldata;
  logic [7:0]  lctrl;
  logic        mac_valid;
  logic [63:0] mac_data;
  logic [7:0]  mac_ctrl;
  logic [5:0]  fill;
  logic        drop;
  logic        del;
  logic        ins;
  logic        flt;
  logic [71:0] got;
  int          error_cnt;
  int          compares;
  int          n_drop;
  int          n_del;
  int          n_ins;
  int          n_flt;

  rmeb_link_src src_u (.en(en), .link_clk(lclk), .link_valid(lvalid), .link_data(ldata), .link_ctrl(lctrl));
  // Read tick every 7 cycles against one word per 8: the local side runs fast
  rmeb_top #(.RD_DIV(7)) dut_u (.core_clk(core_clk), .reset_n(reset_n), .rx_link_clk(lclk),
    .rx_link_valid(lvalid), .rx_link_data(ldata), .rx_link_ctrl(lctrl), .mac_valid(mac_valid),
    .mac_ready(mac_ready), .mac_data(mac_data), .mac_ctrl(mac_ctrl), .fill_level_ff(fill),
    .drop_pulse_ff(drop), .delete_pulse_ff(del), .insert_pulse_ff(ins), .fault_pulse_ff(flt));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    n_drop <= n_drop + (drop === 1'b1);
    n_del <= n_del + (del === 1'b1);
    n_ins <= n_ins + (ins === 1'b1);
    n_flt <= n_flt + (flt === 1'b1);
  end

  function automatic logic [71:0] fw(input int i);
    if (i == 0)
      return {8'h01, 56'h0, `RMEB_START_CODE};
    if (i == 7)
      return {8'hFF, 56'h0707_0707_0707_07, `RMEB_TERM_CODE};
    return {8'h00, 64'(i)};
  endfunction

  task tally_and_finish;
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task get;
    int i;
    for (i = 0; i < 300; i++)
    begin
      @(posedge core_clk);
      if (mac_valid === 1'b1 && mac_ready === 1'b1)
        break;
    end
    if (i == 300)
    begin
      error_cnt++;
      $display("mismatch at %0t: no output word", $time);
      tally_and_finish();
    end
    got = {mac_ctrl, mac_data};
  endtask

  task t_fault;
    mac_ready <= 1'b1;
    repeat (4)
    begin
      get();
      chk(got === LF, "no fault word");
    end
    mac_ready <= 1'b0;
    cyc(150);
  endtask

  task t_fill;
    int k;
    en <= 1'b1;
    cyc(400);
    chk(fill === 6'd17, "fill not held at half");
    chk(n_del > 0 && n_drop == 0, "idle not deleted");
    for (k = 0; k < 24; k++)
      src_u.send({8'h00, 64'(k)});
    cyc(280);
    chk(fill === 6'd32, "store not 32 deep");
    chk(n_drop >= 9, "full write kept");
  endtask

  task t_drain;
    int k;
    int n;
    k = 0;
    mac_ready <= 1'b1;
    for (n = 0; n < 300 && k < 15; n++)
    begin
      get();
      if (got[71:64] === 8'h00)
      begin
        chk(got === {8'h00, 64'(k)}, "stored word wrong");
        k++;
      end
    end
    chk(k == 15, "stored words lost");
    repeat (60)
    begin
      get();
      chk(got[71:64] !== 8'h00, "dropped word came out");
    end
  endtask

  task t_steady;
    int i0;
    int f0;
    int d0;
    cyc(600);
    i0 = n_ins;
    f0 = n_flt;
    d0 = n_drop;
    repeat (100)
    begin
      get();
      chk(got === IDLE, "not idle");
    end
    chk(n_ins > i0 && n_flt == f0 && n_drop == d0, "rate not matched");
    chk(fill >= 6'd12 && fill <= 6'd17, "fill away from half");
  endtask

  task t_frame;
    int i;
    for (i = 0; i < 8; i++)
      src_u.send(fw(i));
    for (i = 0; i < 100 && got !== fw(0); i++)
      get();
    for (i = 1; i < 8; i++)
    begin
      get();
      chk(got === fw(i), "frame split");
    end
  endtask

  initial
  begin
    reset_n = 1'b0;
    mac_ready = 1'b0;
    en = 1'b0;
    error_cnt = 0;
    compares = 0;
    n_drop = 0;
    n_del = 0;
    n_ins = 0;
    n_flt = 0;
    cyc(16);
    chk(mac_valid === 1'b0 && fill === 6'd0, "reset state");
    reset_n <= 1'b1;
    cyc(150);
    t_fault();
    t_fill();
    t_drain();
    t_steady();
    t_frame();
    tally_and_finish();
  end
endmodule

bind rmeb_top rmeb_chk #(.AW(AW)) chk_u (.core_clk(core_clk), .reset_n(reset_n), .mac_valid(mac_valid),
  .mac_ready(mac_ready), .mac_data(mac_data), .mac_ctrl(mac_ctrl), .fill_level_ff(fill_level_ff),
  .drop_pulse_ff(drop_pulse_ff), .delete_pulse_ff(delete_pulse_ff), .insert_pulse_ff(insert_pulse_ff),
  .fault_pulse_ff(fault_pulse_ff));
`default_nettype wire
